// *** verilog/dck_pkg.sv ***
// Purpose: constants and types shared by the clock-enable and command state logic
// Assumes: one 40 MHz clock; all pins sampled on its rising edge
// Notes: precharge and mode-set times are kept in picoseconds and turned into cycle counts here; other times are given in cycles
//
// Operation
// R1: after self refresh exit, idle commands, reads wait
// R2: self refresh only from all banks idle
// R3: power-down entry and exit carry only idle commands
// R4: self refresh exit edge carries only idle commands
// R5: enter active or precharge power-down by banks
// R6: no power-down while operations still busy
// R7: hold clock enable for three sampled edges
// R8: power-down performs no refresh; controller limits it
// R9: clock enable stays high during driver calibration
// R10: termination input driven defined during power-down
// R11: no termination in self refresh, no effect
// R12: masked write bytes are discarded, others stored
// R13: deselect takes no command, work continues
// R14: no-operation causes nothing new, work continues
// R15: mode set only all idle, then wait
// R16: bank bits pick mode register, address is value
// R17: activate opens row until precharged
// R18: read bursts from open row, A10 auto-closes; reads from a closed bank are flagged only when additive latency is zero
// R19: write bursts into open row, A10 auto-closes; writes to a closed bank are flagged only when additive latency is zero
// R20: additive latency delays internal read/write acceptance
// R21: only legal enable and command combinations used
// R22: commands decoded from pins on rising edge
// R23: controller waits precharge time before activate
// R24: controller tracks open or idle bank state
package dck_pkg;

	localparam int CLK_PERIOD_PS = 25000;
	localparam int TRP_PS = 15000;
	localparam int TMRD_PS = 50000;
	localparam int TRP_CYC = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TMRD_CYC = (TMRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TXSRD_CYC = 200;
	localparam int TXSNR_CYC = 8;
	localparam int CKE_MIN_CYC = 3;
	localparam int BL_BEATS = 4;
	localparam int MAX_AL = 6;
	localparam int AP_BIT = 10;
	localparam int COL_W = 10;
	localparam int AL_LSB = 3;
	localparam int ODT_EN_A = 2;
	localparam int ODT_EN_B = 6;
	localparam int MR_ODT_SEL = 1;
	localparam int NUM_MR = 4;

	typedef enum logic [2:0]
	{
		CMD_DES = 3'h0,
		CMD_NOP = 3'h1,
		CMD_MRS = 3'h2,
		CMD_REF = 3'h3,
		CMD_PRE = 3'h4,
		CMD_ACT = 3'h5,
		CMD_WR = 3'h6,
		CMD_RD = 3'h7
	} dck_cmd_e;

	typedef enum logic [1:0]
	{
		ST_RUN = 2'h0,
		ST_PPD = 2'h1,
		ST_APD = 2'h3,
		ST_SREF = 2'h2
	} dck_state_e;

endpackage

// *** verilog/dck_al_if.sv ***
// Purpose: carries read/write commands into and out of the additive latency delay
// Assumes: single clock domain
// Notes: src side drives the command, dly side returns it after the latency
interface dck_al_if;
	logic in_valid;
	logic in_wr;
	logic in_ap;
	logic [2:0] in_bank;
	logic [9:0] in_col;
	logic [2:0] al;
	logic out_valid;
	logic out_wr;
	logic out_ap;
	logic [2:0] out_bank;
	logic [9:0] out_col;

	modport src (output in_valid, in_wr, in_ap, in_bank, in_col, al,
		input out_valid, out_wr, out_ap, out_bank, out_col);
	modport dly (input in_valid, in_wr, in_ap, in_bank, in_col, al,
		output out_valid, out_wr, out_ap, out_bank, out_col);
endinterface

// *** verilog/dck_al_delay.sv ***
// Purpose: delays read/write commands by the programmed additive latency
// Assumes: latency above the depth is clipped to the depth
// Notes: a latency of zero passes the command straight through
module dck_al_delay
	import dck_pkg::*;
#(
	parameter int DEPTH = MAX_AL
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	dck_al_if.dly al_if
);
	localparam int CW = 16;

	logic [CW-1:0] stage_reg [DEPTH];
	logic [CW-1:0] in_word;
	logic [CW-1:0] out_word;
	logic [2:0] tap;

	assign in_word = {al_if.in_valid, al_if.in_wr, al_if.in_ap, al_if.in_bank, al_if.in_col};
	assign tap = (al_if.al > 3'(DEPTH)) ? 3'(DEPTH) : al_if.al;

	// ******************************************************
	// shift stages
	// ******************************************************
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_stage
			if (gi == 0)
			begin : g_head
				always_ff @(posedge clk_i or negedge reset_n_i)
				begin
					if (!reset_n_i)
						stage_reg[gi] <= '0;
					else
						stage_reg[gi] <= in_word;
				end
			end
			else
			begin : g_tail
				always_ff @(posedge clk_i or negedge reset_n_i)
				begin
					if (!reset_n_i)
						stage_reg[gi] <= '0;
					else
						stage_reg[gi] <= stage_reg[gi-1];
				end
			end
		end
	endgenerate

	// command leaves after al cycles, clipped to DEPTH cycles [R20]
	assign out_word = (tap == 3'h0) ? in_word : stage_reg[tap - 3'h1];
	assign {al_if.out_valid, al_if.out_wr, al_if.out_ap, al_if.out_bank, al_if.out_col} = out_word;

	AST_AL_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R20]
		(tap == 3'h0 && al_if.in_valid) |-> al_if.out_valid)
		else $error("zero latency command not passed through");
	AST_AL_TWO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R20]
		(tap == 3'h2 && al_if.in_valid) ##1 (tap == 3'h2) |-> ##1 al_if.out_valid)
		else $error("latency two command not delivered after two cycles");
endmodule

// *** verilog/dck_cmd_state.sv ***
// Purpose: clock-enable driven power states and command execution of the memory device
// Assumes: pins are synchronous to clk_i; one data beat per clock
// Notes: illegal commands are not executed, early clock-enable changes still take effect; each raises a one-cycle error pulse
module dck_cmd_state
	import dck_pkg::*;
#(
	parameter int DQ_W = 8,
	parameter int ADDR_W = 14,
	parameter int XSRD_CYC = TXSRD_CYC
)
(
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic ras_n_i,
	input wire logic cas_n_i,
	input wire logic we_n_i,
	input wire logic [2:0] ba_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic odt_i,
	input wire logic dm_i,
	input wire logic [DQ_W-1:0] dq_i,
	output dck_pkg::dck_state_e state_o,
	output logic [7:0] bank_open_o,
	output logic acc_rd_o,
	output logic acc_wr_o,
	output logic acc_ap_o,
	output logic [2:0] acc_bank_o,
	output logic [9:0] acc_col_o,
	output logic mem_wr_en_o,
	output logic [DQ_W-1:0] mem_wdata_o,
	output logic mode_wr_o,
	output logic [1:0] mode_sel_o,
	output logic [ADDR_W-1:0] mode_val_o,
	output logic odt_on_o,
	output logic cmd_err_o
);
	// ******************************************************
	// decode
	// ******************************************************
	function automatic dck_cmd_e decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		if (cs_n)
			return CMD_DES;
		return dck_cmd_e'({~ras_n, ~cas_n, ~we_n} == 3'h0 ? CMD_NOP :
			{ras_n, cas_n, we_n} == 3'h0 ? CMD_MRS :
			{ras_n, cas_n, we_n} == 3'h1 ? CMD_REF :
			{ras_n, cas_n, we_n} == 3'h2 ? CMD_PRE :
			{ras_n, cas_n, we_n} == 3'h3 ? CMD_ACT :
			{ras_n, cas_n, we_n} == 3'h4 ? CMD_WR : CMD_RD);
	endfunction

	function automatic logic is_idle(input dck_cmd_e c);
		return (c == CMD_DES) || (c == CMD_NOP);
	endfunction

	dck_state_e state_reg;
	dck_state_e state_next;
	dck_cmd_e cmd;
	logic cke_prev_reg;
	logic [1:0] cke_run_reg;
	logic [7:0] bank_open_reg;
	logic [ADDR_W-1:0] mr_reg [NUM_MR];
	logic [3:0] mrd_cnt_reg;
	logic [3:0] trp_cnt_reg;
	logic [7:0] xsrd_cnt_reg;
	logic [7:0] xsnr_cnt_reg;
	logic [3:0] burst_cnt_reg;
	logic burst_wr_reg;
	logic burst_ap_reg;
	logic [2:0] burst_bank_reg;
	logic busy;
	logic run_cmd;
	logic cmd_ok;
	logic err;
	logic burst_last;

	dck_al_if al_if ();

	assign cmd = decode(cs_n_i, ras_n_i, cas_n_i, we_n_i); // [R22]
	assign busy = (burst_cnt_reg != 4'h0) || (mrd_cnt_reg != 4'h0) || (trp_cnt_reg != 4'h0);
	assign run_cmd = (state_reg == ST_RUN) && cke_prev_reg && cke_i;
	assign burst_last = (burst_cnt_reg == 4'h1);

	// ******************************************************
	// command legality while running
	// ******************************************************
	always_comb
	begin
		cmd_ok = 1'b1;
		// reserved pin pattern would otherwise decode as a read
		if (!cs_n_i && ras_n_i && cas_n_i && !we_n_i)
			cmd_ok = 1'b0; // [R21]
		else if (xsnr_cnt_reg != 8'h0 && !is_idle(cmd))
			cmd_ok = 1'b0; // [R1]
		else if (cmd == CMD_RD && xsrd_cnt_reg != 8'h0)
			cmd_ok = 1'b0; // [R1]
		else if (!is_idle(cmd) && mrd_cnt_reg != 4'h0)
			cmd_ok = 1'b0; // [R15]
		else if (cmd == CMD_MRS && (bank_open_reg != 8'h0 || busy))
			cmd_ok = 1'b0; // [R15]
		else if (cmd == CMD_REF && bank_open_reg != 8'h0)
			cmd_ok = 1'b0;
		else if (cmd == CMD_ACT && (bank_open_reg[ba_i] || trp_cnt_reg != 4'h0))
			cmd_ok = 1'b0; // [R17] [R23]
		else if ((cmd == CMD_RD || cmd == CMD_WR) && !bank_open_reg[ba_i] && al_if.al == 3'h0)
			cmd_ok = 1'b0; // [R18] [R19]
	end

	// ******************************************************
	// power state machine
	// ******************************************************
	always_comb
	begin
		state_next = state_reg;
		err = 1'b0;
		if (cke_prev_reg != cke_i && cke_run_reg < 2'(CKE_MIN_CYC))
			err = 1'b1; // [R7]
		case (state_reg)
			ST_RUN:
			begin
				if (cke_prev_reg && !cke_i)
				begin
					if (busy)
						err = 1'b1; // [R6]
					else if (cmd == CMD_REF && bank_open_reg == 8'h0)
						state_next = ST_SREF; // [R2]
					else if (!is_idle(cmd))
						err = 1'b1; // [R3] [R21]
					else if (bank_open_reg != 8'h0)
						state_next = ST_APD; // [R5]
					else
						state_next = ST_PPD; // [R5]
				end
				else if (run_cmd && !cmd_ok)
					err = 1'b1; // [R21]
			end
			ST_PPD, ST_APD, ST_SREF:
			begin
				// nothing is refreshed while powered down [R8]
				if (cke_i)
				begin
					state_next = ST_RUN;
					if (!is_idle(cmd))
						err = 1'b1; // [R3] [R4]
				end
			end
			default:
				state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next; // [R5] [R11]
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cke_prev_reg <= 1'b0;
			cke_run_reg <= 2'(CKE_MIN_CYC);
		end
		else
		begin
			cke_prev_reg <= cke_i;
			if (cke_prev_reg != cke_i)
				cke_run_reg <= 2'h1;
			else if (cke_run_reg < 2'(CKE_MIN_CYC))
				cke_run_reg <= cke_run_reg + 2'h1; // [R7]
		end
	end

	// self refresh exit windows
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			xsrd_cnt_reg <= 8'h0;
			xsnr_cnt_reg <= 8'h0;
		end
		else if (state_reg == ST_SREF && state_next == ST_RUN)
		begin
			xsrd_cnt_reg <= 8'(XSRD_CYC); // [R1]
			xsnr_cnt_reg <= 8'(TXSNR_CYC);
		end
		else
		begin
			if (xsrd_cnt_reg != 8'h0)
				xsrd_cnt_reg <= xsrd_cnt_reg - 8'h1;
			if (xsnr_cnt_reg != 8'h0)
				xsnr_cnt_reg <= xsnr_cnt_reg - 8'h1;
		end
	end

	// ******************************************************
	// mode registers
	// ******************************************************
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < NUM_MR; i++)
				mr_reg[i] <= '0;
			mrd_cnt_reg <= 4'h0;
		end
		else if (run_cmd && cmd_ok && cmd == CMD_MRS)
		begin
			mr_reg[ba_i[1:0]] <= addr_i; // [R16]
			mrd_cnt_reg <= 4'(TMRD_CYC); // [R15]
		end
		else if (mrd_cnt_reg != 4'h0)
			mrd_cnt_reg <= mrd_cnt_reg - 4'h1;
	end

	// ******************************************************
	// banks and bursts
	// ******************************************************
	assign al_if.in_valid = run_cmd && cmd_ok && (cmd == CMD_RD || cmd == CMD_WR);
	assign al_if.in_wr = (cmd == CMD_WR);
	assign al_if.in_ap = addr_i[AP_BIT];
	assign al_if.in_bank = ba_i;
	assign al_if.in_col = addr_i[COL_W-1:0];
	assign al_if.al = mr_reg[MR_ODT_SEL][AL_LSB +: 3];

	dck_al_delay #(.DEPTH(MAX_AL)) u_al_delay (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.al_if(al_if)
	);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bank_open_reg <= 8'h0;
			trp_cnt_reg <= 4'h0;
		end
		else
		begin
			if (trp_cnt_reg != 4'h0)
				trp_cnt_reg <= trp_cnt_reg - 4'h1;
			if (burst_cnt_reg != 4'h0 && burst_last && burst_ap_reg)
			begin
				bank_open_reg[burst_bank_reg] <= 1'b0; // [R18] [R19]
				trp_cnt_reg <= 4'(TRP_CYC);
			end
			// deselect and no-operation leave the bank state alone [R13] [R14]
			if (run_cmd && cmd_ok && cmd == CMD_ACT)
				bank_open_reg[ba_i] <= 1'b1; // [R17]
			else if (run_cmd && cmd_ok && cmd == CMD_PRE)
			begin
				if (addr_i[AP_BIT])
					bank_open_reg <= 8'h0;
				else
					bank_open_reg[ba_i] <= 1'b0; // [R17]
				trp_cnt_reg <= 4'(TRP_CYC);
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			burst_cnt_reg <= 4'h0;
			burst_wr_reg <= 1'b0;
			burst_ap_reg <= 1'b0;
			burst_bank_reg <= 3'h0;
		end
		else if (al_if.out_valid)
		begin
			burst_cnt_reg <= 4'(BL_BEATS); // [R20]
			burst_wr_reg <= al_if.out_wr;
			burst_ap_reg <= al_if.out_ap;
			burst_bank_reg <= al_if.out_bank;
		end
		else if (burst_cnt_reg != 4'h0)
			burst_cnt_reg <= burst_cnt_reg - 4'h1;
	end

	// ******************************************************
	// registered outputs
	// ******************************************************
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			acc_rd_o <= 1'b0;
			acc_wr_o <= 1'b0;
			acc_ap_o <= 1'b0;
			acc_bank_o <= 3'h0;
			acc_col_o <= 10'h0;
		end
		else
		begin
			acc_rd_o <= al_if.out_valid && !al_if.out_wr; // [R18] [R20]
			acc_wr_o <= al_if.out_valid && al_if.out_wr; // [R19] [R20]
			acc_ap_o <= al_if.out_ap;
			acc_bank_o <= al_if.out_bank;
			acc_col_o <= al_if.out_col;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mem_wr_en_o <= 1'b0;
			mem_wdata_o <= '0;
		end
		else
		begin
			mem_wr_en_o <= (burst_cnt_reg != 4'h0) && burst_wr_reg && !dm_i; // [R12]
			mem_wdata_o <= dq_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_wr_o <= 1'b0;
			mode_sel_o <= 2'h0;
			mode_val_o <= '0;
			odt_on_o <= 1'b0;
			cmd_err_o <= 1'b0;
		end
		else
		begin
			mode_wr_o <= run_cmd && cmd_ok && cmd == CMD_MRS; // [R16]
			mode_sel_o <= ba_i[1:0];
			mode_val_o <= addr_i;
			odt_on_o <= odt_i && state_next != ST_SREF &&
				(mr_reg[MR_ODT_SEL][ODT_EN_A] || mr_reg[MR_ODT_SEL][ODT_EN_B]); // [R11] [R10]
			cmd_err_o <= err;
		end
	end

	assign state_o = state_reg;
	assign bank_open_o = bank_open_reg;

	// ******************************************************
	// checks
	// ******************************************************
	AST_APD_ENTRY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
		(state_reg == ST_RUN && cke_prev_reg && !cke_i && is_idle(cmd) && !busy &&
		bank_open_reg != 8'h0) |=> (state_reg == ST_APD))
		else $error("active power-down not entered");
	AST_PPD_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R5]
		(state_reg == ST_PPD && !cke_i) |=> (state_reg == ST_PPD))
		else $error("precharge power-down left while clock enable low");
	AST_SREF_ENTRY: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
		(state_reg == ST_RUN && cke_prev_reg && !cke_i && cmd == CMD_REF && !busy)
		|=> (state_reg == (($past(bank_open_reg) == 8'h0) ? ST_SREF : ST_RUN)))
		else $error("self refresh entry wrong");
	AST_BUSY_PD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R6]
		(state_reg == ST_RUN && cke_prev_reg && !cke_i && busy)
		|=> (state_reg == ST_RUN) && cmd_err_o)
		else $error("power-down entered while busy");
	AST_ACT_OPEN: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R17]
		(run_cmd && cmd_ok && cmd == CMD_ACT) |=> bank_open_reg[$past(ba_i)])
		else $error("activate did not open bank");
	AST_DES_NOCHG: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R13]
		(run_cmd && cmd == CMD_DES && burst_cnt_reg == 4'h0) |=> $stable(bank_open_reg))
		else $error("deselect changed bank state");
	AST_NOP_NOMODE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R14]
		(cmd == CMD_NOP && !al_if.out_valid) |=> !mode_wr_o && !acc_rd_o && !acc_wr_o)
		else $error("no-operation started an action");
	AST_MASK: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R12]
		(burst_cnt_reg != 4'h0 && burst_wr_reg) |=> (mem_wr_en_o == !$past(dm_i)))
		else $error("write mask not honoured");
	AST_ODT_SREF: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
		(state_reg == ST_SREF) ##1 (state_reg == ST_SREF) |-> !odt_on_o)
		else $error("termination on in self refresh");
	AST_XSRD_RD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
		(run_cmd && cmd == CMD_RD && xsrd_cnt_reg != 8'h0) |=> cmd_err_o ##1 !acc_rd_o)
		else $error("early read after self refresh accepted");
	AST_AP_CLOSE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R18]
		(burst_cnt_reg == 4'h1 && burst_ap_reg && !al_if.out_valid)
		|=> !bank_open_reg[$past(burst_bank_reg)] || $past(run_cmd && cmd == CMD_ACT))
		else $error("auto precharge did not close bank");

	COV_SREF: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		state_reg == ST_RUN ##1 state_reg == ST_SREF ##[1:20] state_reg == ST_RUN);
	COV_APD: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		state_reg == ST_APD);
	COV_MASKED: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		burst_cnt_reg != 4'h0 && burst_wr_reg && dm_i);
	COV_AP_RD: cover property (@(posedge clk_i) disable iff (!reset_n_i)
		acc_rd_o && acc_ap_o);
endmodule

// *** test/dck_ctl_model.sv ***
// Purpose: behavioural memory controller driving command, mask and data pins
// Assumes: tasks are entered just after a rising edge; send returns just after the next, issue after its last send, data at once
// Notes: idle commands are inserted wherever a hold or wait time would break
module dck_ctl_model
	import dck_pkg::*;
#(
	parameter int XSRD = 20
)
(
	input wire logic clk_i,
	output logic cke_o,
	output logic cs_n_o,
	output logic ras_n_o,
	output logic cas_n_o,
	output logic we_n_o,
	output logic [2:0] ba_o,
	output logic [13:0] addr_o,
	output logic dm_o,
	output logic [7:0] dq_o
);
	timeunit 1ns;
	timeprecision 100ps;

	int quiet = 0;
	int rd_wait = 0;
	int cke_age = 3;
	logic in_sref = 1'b0;
	logic dat_pend = 1'b0;
	logic [7:0] open_q = 8'h00;

	initial
	begin
		cke_o = 1'b0;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
		ba_o = 3'h0;
		addr_o = 14'h0000;
		dm_o = 1'b1;
		dq_o = 8'h00;
	end

	// ***********************************
	// pin drivers
	// ***********************************
	task automatic data(input logic dm, input logic [7:0] dq);
		dm_o = dm;
		dq_o = dq;
		dat_pend = 1'b1;
	endtask

	task automatic send(input logic cke, input dck_cmd_e cmd, input logic [2:0] ba,
		input logic [13:0] addr);
		logic [3:0] pins;
		cke_age = (cke == cke_o) ? cke_age + 1 : 1;
		quiet = (quiet > 0) ? quiet - 1 : 0;
		rd_wait = (rd_wait > 0) ? rd_wait - 1 : 0;
		if (!dat_pend)
		begin
			dm_o = ~dm_o;
			dq_o = ~dq_o;
		end
		dat_pend = 1'b0;
		pins = (cmd == CMD_DES) ? {1'b1, ~ras_n_o, ~cas_n_o, ~we_n_o} :
			(cmd == CMD_NOP) ? 4'h7 : {1'b0, cmd - 3'h2};
		if (cmd == CMD_MRS)
			quiet = TMRD_CYC + 1;
		if (cmd == CMD_PRE)
			quiet = TRP_CYC + 1;
		if (cmd >= CMD_WR)
			quiet = BL_BEATS + MAX_AL + 1;
		if (cmd == CMD_ACT)
			open_q[ba] = 1'b1;
		if (cmd == CMD_PRE || (cmd >= CMD_WR && addr[10]))
			open_q = (cmd == CMD_PRE && addr[10]) ? 8'h00 : open_q & ~(8'h01 << ba);
		if (cke_o && !cke && cmd == CMD_REF)
			in_sref = 1'b1;
		if (!cke_o && cke && in_sref)
		begin
			in_sref = 1'b0;
			quiet = TXSNR_CYC + 1;
			rd_wait = XSRD + 1;
		end
		cke_o = cke;
		{cs_n_o, ras_n_o, cas_n_o, we_n_o} = pins;
		ba_o = (cmd == CMD_DES) ? ~ba_o : ba;
		addr_o = (cmd == CMD_DES) ? ~addr_o : addr;
		@(posedge clk_i);
		#1;
	endtask

	task automatic issue(input logic cke, input dck_cmd_e cmd, input logic [2:0] ba,
		input logic [13:0] addr);
		while ((cke != cke_o && cke_age < CKE_MIN_CYC) ||
			(quiet > 0 && (cmd > CMD_NOP || cke != cke_o)) || (cmd == CMD_RD && rd_wait > 0))
			send(cke_o, CMD_NOP, 3'h0, 14'h0000);
		send(cke, cmd, ba, addr);
	endtask
endmodule

// *** test/tb.sv ***
// Purpose: self-checking bench for the clock-enable and command state logic
// Assumes: controller model drives all command pins one delay after each edge
// Notes: self refresh read wait shortened to 20 cycles
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import dck_pkg::*;

	logic clk_i;
	logic reset_n_i = 1'b0;
	logic odt_i = 1'b0;
	logic cke, cs_n, ras_n, cas_n, we_n, dm;
	logic [2:0] ba;
	logic [13:0] addr;
	logic [7:0] dq;
	dck_state_e state_o;
	logic [7:0] bank_open_o, mem_wdata_o;
	logic acc_rd_o, acc_wr_o, acc_ap_o, mem_wr_en_o, mode_wr_o, odt_on_o, cmd_err_o;
	logic [2:0] acc_bank_o;
	logic [9:0] acc_col_o;
	logic [1:0] mode_sel_o;
	logic [13:0] mode_val_o;
	int miscompares = 0;
	int total_checks = 0;

	dck_ctl_model #(.XSRD(20)) ctl_u (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n),
		.ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n), .ba_o(ba), .addr_o(addr),
		.dm_o(dm), .dq_o(dq));

	dck_cmd_state #(.XSRD_CYC(20)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
		.ba_i(ba), .addr_i(addr), .odt_i(odt_i), .dm_i(dm), .dq_i(dq),
		.state_o(state_o), .bank_open_o(bank_open_o), .acc_rd_o(acc_rd_o),
		.acc_wr_o(acc_wr_o), .acc_ap_o(acc_ap_o), .acc_bank_o(acc_bank_o),
		.acc_col_o(acc_col_o), .mem_wr_en_o(mem_wr_en_o), .mem_wdata_o(mem_wdata_o),
		.mode_wr_o(mode_wr_o), .mode_sel_o(mode_sel_o), .mode_val_o(mode_val_o),
		.odt_on_o(odt_on_o), .cmd_err_o(cmd_err_o));

	// ***********************************
	// checking and reporting
	// ***********************************
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_st(input dck_state_e got, input dck_state_e exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t state got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d miscompares=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ***********************************
	// scenarios
	// ***********************************
	task automatic t_mrs;
		logic [13:0] val [4];
		val = '{14'h0123, 14'h0044, 14'h0080, 14'h0000};
		for (int s = 0; s < NUM_MR; s++)
		begin
			ctl_u.issue(1'b1, CMD_MRS, 3'(s), val[s]);
			chk(16'(mode_wr_o), 16'h0001);
			chk(16'(mode_sel_o), 16'(s));
			chk(16'(mode_val_o), 16'(val[s]));
		end
		$display("test mrs done");
	endtask

	task automatic t_write;
		logic [3:0] mask;
		mask = 4'b0010;
		ctl_u.issue(1'b1, CMD_ACT, 3'h0, 14'h1abc);
		chk(16'(bank_open_o), 16'h0001);
		ctl_u.issue(1'b1, CMD_WR, 3'h0, 14'h0405);
		chk(16'({acc_wr_o, acc_ap_o, acc_col_o}), 16'h0c05);
		for (int i = 0; i < BL_BEATS; i++)
		begin
			ctl_u.data(mask[i], 8'(8'ha0 + i));
			ctl_u.issue(1'b1, (i == 2) ? CMD_DES : CMD_NOP, 3'h0, 14'h0000);
			chk(16'(mem_wr_en_o), 16'(!mask[i]));
			if (!mask[i])
				chk(16'(mem_wdata_o), 16'(8'ha0 + i));
		end
		chk(16'(bank_open_o), 16'h0000);
		$display("test write done");
	endtask

	task automatic t_read_al;
		int n;
		n = 0;
		ctl_u.issue(1'b1, CMD_MRS, 3'h1, 14'h0054);
		ctl_u.issue(1'b1, CMD_ACT, 3'h3, 14'h0011);
		ctl_u.issue(1'b1, CMD_RD, 3'h3, 14'h0007);
		while (acc_rd_o !== 1'b1 && n < 10)
		begin
			ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
			n++;
		end
		chk(16'(n), 16'h0002);
		chk(16'({acc_bank_o, acc_ap_o, acc_col_o}), 16'h1807);
		repeat (BL_BEATS) ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		chk(16'(bank_open_o), 16'h0008);
		$display("test read done");
	endtask

	task automatic t_pd;
		odt_i = 1'b1;
		ctl_u.issue(1'b0, CMD_NOP, 3'h0, 14'h0000);
		chk_st(state_o, ST_APD);
		chk(16'(odt_on_o), 16'h0001);
		ctl_u.issue(1'b0, CMD_DES, 3'h0, 14'h0000);
		chk_st(state_o, ST_APD);
		ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		chk_st(state_o, ST_RUN);
		ctl_u.issue(1'b1, CMD_PRE, 3'h0, 14'h0400);
		chk(16'(bank_open_o), 16'h0000);
		ctl_u.issue(1'b0, CMD_DES, 3'h0, 14'h0000);
		chk_st(state_o, ST_PPD);
		ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		chk_st(state_o, ST_RUN);
		$display("test power-down done");
	endtask

	task automatic t_sref;
		ctl_u.issue(1'b0, CMD_REF, 3'h0, 14'h0000);
		chk_st(state_o, ST_SREF);
		chk(16'(odt_on_o), 16'h0000);
		ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		chk_st(state_o, ST_RUN);
		ctl_u.issue(1'b1, CMD_ACT, 3'h2, 14'h0020);
		chk(16'({cmd_err_o, bank_open_o}), 16'h0004);
		ctl_u.send(1'b1, CMD_REF, 3'h0, 14'h0000);
		chk(16'(cmd_err_o), 16'h0001);
		chk_st(state_o, ST_RUN);
		ctl_u.send(1'b1, CMD_RD, 3'h2, 14'h0003);
		chk(16'({cmd_err_o, acc_rd_o}), 16'h0002);
		ctl_u.issue(1'b1, CMD_RD, 3'h2, 14'h0003);
		repeat (2) ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		chk(16'({cmd_err_o, acc_rd_o}), 16'h0001);
		ctl_u.send(1'b0, CMD_NOP, 3'h0, 14'h0000);
		chk(16'(cmd_err_o), 16'h0001);
		chk_st(state_o, ST_RUN);
		$display("test self refresh done");
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial
	begin
		#(25 * 3000);
		miscompares++;
		$display("ERROR t=%0t watchdog expired got=%h exp=%h", $time, 1'b1, 1'b0);
		print_verdict();
	end

	initial
	begin
		repeat (4) @(posedge clk_i);
		#1;
		reset_n_i = 1'b1;
		chk_st(state_o, ST_RUN);
		chk(16'({acc_rd_o, acc_wr_o, mode_wr_o, cmd_err_o, bank_open_o}), 16'h0000);
		ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		ctl_u.issue(1'b1, CMD_NOP, 3'h0, 14'h0000);
		t_mrs();
		t_write();
		t_read_al();
		t_pd();
		t_sref();
		print_verdict();
	end
endmodule
